// ==== core/ratc_core.sv ====
// Record arm, trigger and re-arm controller
//
// Functional notes
// - Event recognition instant latched as time zero
// - Pre-event window capped at 0.0512 s
// - Level trigger unusable with event-line start
// - Event-line start: no pre-data, lowest power
// - Wake-on-motion leaves low-power armed state
// - Scheduled start at UTC or minute interval
// - Scheduled mode keeps no pre-start samples
// - Multi-event mode re-arms after each recording short of the count
// - Stop re-arming at count or disarm
// - Level trigger on rise above / below
// - Thresholds checked on high-g channels only
// - Host command starts collection like event
// - Recording to flash runs without host
//
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module ratc_core
    import ratc_pkg::*;
#(
    parameter int MIN_CYCLES = MIN_CYC
)(
    input  wire logic                     clk,
    input  wire logic                     sys_rst,
    input  wire logic [3:0]               reg_addr,
    input  wire logic [31:0]              reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic [31:0]                   reg_rdata,
    input  wire logic                     event_n,
    input  wire logic                     motion,
    input  wire logic                     smp_valid,
    input  wire logic [HIGHG_N*SMP_W-1:0] smp_highg,
    input  wire logic                     rec_done,
    output logic                          rec_start,
    output logic                          rec_active,
    output logic [PRE_W-1:0]              rec_pre_len,
    output logic                          low_power,
    output logic                          irq
);
    ////////////////////////////////////////////////////////////////////
    ratc_state_t          state;
    logic [6:0]           ctrl;
    logic [CNT_W-1:0]     evt_count;
    logic [CNT_W-1:0]     done_cnt;
    logic signed [SMP_W-1:0] thr_hi;
    logic signed [SMP_W-1:0] thr_lo;
    logic [TIME_W-1:0]    sched_utc;
    logic [TIME_W-1:0]    interval;
    logic [TIME_W-1:0]    utc_now;
    logic [TIME_W-1:0]    t0_stamp;
    logic [TIME_W-1:0]    min_left;
    logic [31:0]          sec_div;
    logic [31:0]          min_div;
    logic [I_W-1:0]       irq_stat;
    logic [I_W-1:0]       irq_mask;
    logic [PRE_W-1:0]     pre_len;
    logic                 ev_s1;
    logic                 ev_s2;
    logic                 ev_s3;
    logic                 mo_s1;
    logic                 mo_s2;
    logic                 sec_tick;
    logic                 min_tick;
    logic                 cmd_wr;
    logic                 lvl_en;
    logic                 ev_edge;
    logic                 lvl_hit;
    logic                 sched_hit;
    logic                 trig;
    logic                 finish;
    logic [HIGHG_N-1:0]   ch_hit;

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ev_s1 <= 1'b0;
            ev_s2 <= 1'b0;
            ev_s3 <= 1'b0;
            mo_s1 <= 1'b0;
            mo_s2 <= 1'b0;
        end
        else
        begin
            ev_s1 <= ~event_n;
            ev_s2 <= ev_s1;
            ev_s3 <= ev_s2;
            mo_s1 <= motion;
            mo_s2 <= mo_s1;
        end
    end

    // Contact closure seen on its leading edge
    assign ev_edge = ev_s2 & ~ev_s3;

    ////////////////////////////////////////////////////////////////////
    // Timebase: seconds for UTC, minutes for interval
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sec_div <= 32'h0;
            min_div <= 32'h0;
        end
        else
        begin
            sec_div <= sec_tick ? 32'h0 : sec_div + 32'h1;
            min_div <= (min_tick || state != RATC_ARMED) ? 32'h0 : min_div + 32'h1;
        end
    end

    assign sec_tick = (sec_div == 32'(CLK_HZ - 1));
    assign min_tick = (min_div == 32'(MIN_CYCLES - 1));

    ////////////////////////////////////////////////////////////////////
    // Trigger sources
    assign lvl_en = ctrl[C_LEVEL] & ~ctrl[C_EVLINE] & ~ctrl[C_SCHED];

    genvar g;
    generate
        for (g = 0; g < HIGHG_N; g++)
        begin : g_ch
            logic signed [SMP_W-1:0] s;
            assign s         = smp_highg[g*SMP_W +: SMP_W];
            assign ch_hit[g] = (s > thr_hi) || (s < thr_lo);
        end
    endgenerate

    assign lvl_hit   = lvl_en & smp_valid & (|ch_hit);
    assign sched_hit = ctrl[C_SCHED] & (ctrl[C_USE_INT] ? (min_tick && min_left <= 32'h1)
                                                        : (sec_tick && utc_now == sched_utc));
    assign cmd_wr    = reg_wr && reg_addr == A_CMD;
    assign trig      = (state == RATC_ARMED) && !(cmd_wr && reg_wdata[K_DISARM]) &&
                       ((!ctrl[C_SCHED] && ev_edge) || lvl_hit || sched_hit ||
                        (cmd_wr && reg_wdata[K_START]));
    assign finish    = (state == RATC_REC) && rec_done &&
                       (!ctrl[C_MULTI] || done_cnt + 16'h1 >= evt_count);

    // Pre-event length: none for event-line and scheduled starts
    always_comb
    begin
        if (ctrl[C_SCHED] || ctrl[C_EVLINE])
            pre_len = '0;
        else if (ctrl[C_PRE])
            pre_len = PRE_W'(PRE_MAX_CYC);
        else
            pre_len = '0;
    end

    ////////////////////////////////////////////////////////////////////
    // Arm state machine
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            state <= RATC_IDLE;
        else
        begin
            case (state)
                RATC_IDLE:
                    if (cmd_wr && reg_wdata[K_ARM] && !reg_wdata[K_DISARM])
                        state <= (ctrl[C_EVLINE] || ctrl[C_MOTION]) ? RATC_SLEEP : RATC_ARMED;
                RATC_SLEEP:
                    if (cmd_wr && reg_wdata[K_DISARM])
                        state <= RATC_IDLE;
                    else if (ctrl[C_MOTION] ? mo_s2 : 1'b1)
                        state <= RATC_ARMED;
                RATC_ARMED:
                    if (cmd_wr && reg_wdata[K_DISARM])
                        state <= RATC_IDLE;
                    else if (trig)
                        state <= RATC_REC;
                RATC_REC:
                    // Start commands and triggers have no effect here
                    if (rec_done)
                        state <= finish ? RATC_IDLE : RATC_ARMED;
                default:
                    state <= RATC_IDLE;
            endcase
        end
    end

    // Event-line armed unit sleeps until the closure itself
    assign low_power  = (state == RATC_SLEEP) ||
                        (state == RATC_ARMED && ctrl[C_EVLINE]);
    assign rec_active = (state == RATC_REC);
    assign rec_start  = trig;
    assign rec_pre_len = pre_len;

    ////////////////////////////////////////////////////////////////////
    // Counters, clock and time zero
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            done_cnt <= '0;
            t0_stamp <= '0;
            utc_now  <= '0;
            min_left <= '0;
        end
        else
        begin
            if (reg_wr && reg_addr == A_UTC_NOW)
                utc_now <= reg_wdata;
            else if (sec_tick)
                utc_now <= utc_now + 32'h1;
            if (trig)
                t0_stamp <= utc_now;
            if (state == RATC_IDLE && cmd_wr && reg_wdata[K_ARM])
                done_cnt <= '0;
            else if (state == RATC_REC && rec_done)
                done_cnt <= done_cnt + 16'h1;
            if (state != RATC_ARMED || min_left == '0)
                min_left <= interval;
            else if (min_tick)
                min_left <= min_left - 32'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Configuration registers
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ctrl      <= '0;
            evt_count <= 16'h0001;
            thr_hi    <= 16'h7FFF;
            thr_lo    <= 16'h8000;
            sched_utc <= '0;
            interval  <= 32'h0000_0001;
            irq_mask  <= '0;
        end
        else if (reg_wr && state == RATC_IDLE)
        begin
            case (reg_addr)
                A_CTRL:      ctrl      <= reg_wdata[6:0];
                A_EVT_COUNT: evt_count <= reg_wdata[CNT_W-1:0];
                A_THR_HI:    thr_hi    <= reg_wdata[SMP_W-1:0];
                A_THR_LO:    thr_lo    <= reg_wdata[SMP_W-1:0];
                A_SCHED_UTC: sched_utc <= reg_wdata;
                A_INTERVAL:  interval  <= reg_wdata;
                A_IRQ_MASK:  irq_mask  <= reg_wdata[I_W-1:0];
                default:     ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Interrupt status, cleared by read; a new event wins
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            irq_stat <= '0;
        else
            irq_stat <= ((reg_rd && reg_addr == A_IRQ_STAT) ? '0 : irq_stat) |
                        {finish, state == RATC_REC && rec_done, trig};
    end

    assign irq = |(irq_stat & irq_mask);

    ////////////////////////////////////////////////////////////////////
    // Read port
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            reg_rdata <= '0;
        else if (reg_rd)
        begin
            case (reg_addr)
                A_CTRL:      reg_rdata <= {25'h0, ctrl};
                A_STATUS:    reg_rdata <= {26'h0, ev_s2, low_power, state};
                A_IRQ_STAT:  reg_rdata <= {29'h0, irq_stat};
                A_IRQ_MASK:  reg_rdata <= {29'h0, irq_mask};
                A_EVT_COUNT: reg_rdata <= {16'h0, evt_count};
                A_THR_HI:    reg_rdata <= {16'h0, thr_hi};
                A_THR_LO:    reg_rdata <= {16'h0, thr_lo};
                A_SCHED_UTC: reg_rdata <= sched_utc;
                A_INTERVAL:  reg_rdata <= interval;
                A_UTC_NOW:   reg_rdata <= utc_now;
                A_T0_STAMP:  reg_rdata <= t0_stamp;
                A_DONE_CNT:  reg_rdata <= {16'h0, done_cnt};
                A_PRE_LEN:   reg_rdata <= {12'h0, pre_len};
                default:     reg_rdata <= '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_rec_end;
        rec_active ##1 !rec_active;
    endsequence

    a_trig_enters_rec: assert property (@(posedge clk) disable iff (sys_rst)
        rec_start |=> rec_active)
        else $error("trigger did not start recording");
    a_t0_latched: assert property (@(posedge clk) disable iff (sys_rst)
        rec_start && !(reg_wr && reg_addr == A_UTC_NOW) |=> t0_stamp == $past(utc_now))
        else $error("time zero not latched");
    a_pre_cap: assert property (@(posedge clk) disable iff (sys_rst)
        rec_pre_len <= PRE_W'(PRE_MAX_CYC))
        else $error("pre-event window too long");
    a_no_pre_sched: assert property (@(posedge clk) disable iff (sys_rst)
        ctrl[C_SCHED] |-> rec_pre_len == '0)
        else $error("pre data in scheduled mode");
    a_evline_power: assert property (@(posedge clk) disable iff (sys_rst)
        ctrl[C_EVLINE] && state == RATC_ARMED |-> low_power && rec_pre_len == '0)
        else $error("event line mode not low power");
    a_lvl_excl: assert property (@(posedge clk) disable iff (sys_rst)
        ctrl[C_EVLINE] && smp_valid && !ev_edge && !cmd_wr && !ctrl[C_SCHED] |-> !rec_start)
        else $error("level trigger with event line");
    a_no_retrig: assert property (@(posedge clk) disable iff (sys_rst)
        rec_active |-> !rec_start)
        else $error("trigger during recording");
    a_rearm: assert property (@(posedge clk) disable iff (sys_rst)
        rec_active && rec_done && !finish |=> state == RATC_ARMED)
        else $error("no re-arm after event");
    a_stop_count: assert property (@(posedge clk) disable iff (sys_rst)
        finish |-> s_rec_end ##0 state == RATC_IDLE ##1 !rec_active)
        else $error("re-armed past count");
    a_motion_wake: assert property (@(posedge clk) disable iff (sys_rst)
        state == RATC_SLEEP && ctrl[C_MOTION] && mo_s2 && !cmd_wr |=> state == RATC_ARMED)
        else $error("motion did not wake");
endmodule : ratc_core
`default_nettype wire

// ==== core/ratc_pkg.sv ====
// Constants for the record arm and trigger controller
package ratc_pkg;
    localparam int          CLK_HZ          = 10_000_000;
    localparam int          PRE_MAX_US      = 51_200;
    localparam int          PRE_MAX_CYC     = PRE_MAX_US * (CLK_HZ / 1_000_000);
    localparam int          MIN_US          = 60_000_000;
    localparam int          MIN_CYC         = 600_000_000;
    localparam int          PRE_W           = 20;
    localparam int          HIGHG_N         = 3;
    localparam int          SMP_W           = 16;
    localparam int          CNT_W           = 16;
    localparam int          TIME_W          = 32;
    localparam logic [3:0]  A_CTRL          = 4'h0;
    localparam logic [3:0]  A_CMD           = 4'h1;
    localparam logic [3:0]  A_STATUS        = 4'h2;
    localparam logic [3:0]  A_IRQ_STAT      = 4'h3;
    localparam logic [3:0]  A_IRQ_MASK      = 4'h4;
    localparam logic [3:0]  A_EVT_COUNT     = 4'h5;
    localparam logic [3:0]  A_THR_HI        = 4'h6;
    localparam logic [3:0]  A_THR_LO        = 4'h7;
    localparam logic [3:0]  A_SCHED_UTC     = 4'h8;
    localparam logic [3:0]  A_INTERVAL      = 4'h9;
    localparam logic [3:0]  A_UTC_NOW       = 4'hA;
    localparam logic [3:0]  A_T0_STAMP      = 4'hB;
    localparam logic [3:0]  A_DONE_CNT      = 4'hC;
    localparam logic [3:0]  A_PRE_LEN       = 4'hD;
    // CTRL fields
    localparam int          C_SCHED         = 0;
    localparam int          C_EVLINE        = 1;
    localparam int          C_LEVEL         = 2;
    localparam int          C_MOTION        = 3;
    localparam int          C_MULTI         = 4;
    localparam int          C_USE_INT       = 5;
    localparam int          C_PRE           = 6;
    // CMD fields
    localparam int          K_ARM           = 0;
    localparam int          K_DISARM        = 1;
    localparam int          K_START         = 2;
    // IRQ fields
    localparam int          I_TRIG          = 0;
    localparam int          I_DONE          = 1;
    localparam int          I_FINISH        = 2;
    localparam int          I_W             = 3;
    typedef enum logic [3:0] {
        RATC_IDLE  = 4'b0001,
        RATC_SLEEP = 4'b0010,
        RATC_ARMED = 4'b0100,
        RATC_REC   = 4'b1000
    } ratc_state_t;
endpackage : ratc_pkg

// ==== bench/ratc_partner.sv ====
// Far-side model: contact-closure source and flash recorder stand-in
`timescale 1ns/1ps
`default_nettype none
module ratc_partner #(
    parameter int DONE_DLY = 20
)(
    input  wire logic clk,
    input  wire logic rec_active,
    output var logic  event_n,
    output var logic  rec_done
);
    int cnt = 0;
    initial event_n = 1'b1;
    ////////////////////////////////////////////////////////////////
    // Open contact rests at the pull-up level
    task automatic close_contact(input int hold);
        @(posedge clk);
        event_n <= 1'b0;
        repeat (hold) @(posedge clk);
        event_n <= 1'b1;
    endtask : close_contact
    ////////////////////////////////////////////////////////////////
    // Recording ends by itself, no host in the loop
    always @(posedge clk)
    begin
        rec_done <= 1'b0;
        if (rec_active !== 1'b1)
            cnt <= 0;
        else
        begin
            cnt <= cnt + 1;
            if (cnt == DONE_DLY)
                rec_done <= 1'b1;
        end
    end
endmodule : ratc_partner
`default_nettype wire

// ==== bench/record_arm_trigger_control_test.sv ====
// Testbench for the record arm and trigger controller
`timescale 1ns/1ps
`default_nettype none
module record_arm_trigger_control_test
    import ratc_pkg::*;
;
    logic                     clk;
    logic                     sys_rst;
    logic [3:0]               reg_addr;
    logic [31:0]              reg_wdata;
    logic                     reg_wr;
    logic                     reg_rd;
    logic [31:0]              reg_rdata;
    logic                     event_n;
    logic                     motion;
    logic                     smp_valid;
    logic [HIGHG_N*SMP_W-1:0] smp_highg;
    logic                     rec_done;
    logic                     rec_start;
    logic                     rec_active;
    logic [PRE_W-1:0]         rec_pre_len;
    logic                     low_power;
    logic                     irq;
    logic [31:0]              rd_val;
    int                       fails = 0;
    int                       n_tests = 0;
    int                       n_starts = 0;
    int                       base;
    int                       i;
    ratc_core #(.MIN_CYCLES(20)) dut_u (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .event_n(event_n), .motion(motion), .smp_valid(smp_valid), .smp_highg(smp_highg),
        .rec_done(rec_done), .rec_start(rec_start), .rec_active(rec_active),
        .rec_pre_len(rec_pre_len), .low_power(low_power), .irq(irq));
    ratc_partner #(.DONE_DLY(20)) partner_u (.clk(clk), .rec_active(rec_active),
        .event_n(event_n), .rec_done(rec_done));
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk)
        if (rec_start === 1'b1)
            n_starts <= n_starts + 1;
    ////////////////////////////////////////////////////////////////
    task automatic summarize;
        if (fails == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fails++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd   <= 1'b0;
        @(posedge clk);
        d = reg_rdata;
    endtask : rd
    task automatic rchk(input string name, input logic [3:0] a, input logic [31:0] exp);
        rd(a, rd_val);
        chk(name, rd_val, exp);
    endtask : rchk
    task automatic st(input logic [3:0] exp);
        rd(A_STATUS, rd_val);
        chk("state", {28'h0, rd_val[3:0]}, {28'h0, exp});
    endtask : st
    task automatic wait_act(input logic exp);
        for (int k = 0; k < 60 && rec_active !== exp; k++)
            @(posedge clk);
        chk("rec_active", {31'h0, rec_active}, {31'h0, exp});
    endtask : wait_act
    task automatic smp(input logic [HIGHG_N*SMP_W-1:0] v);
        @(posedge clk);
        smp_valid <= 1'b1;
        smp_highg <= v;
        @(posedge clk);
        smp_valid <= 1'b0;
        @(posedge clk);
    endtask : smp
    ////////////////////////////////////////////////////////////////
    initial
    begin
        #(100 * 20000);
        fails++;
        summarize();
    end
    initial
    begin
        sys_rst = 1'b1;
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        motion = 1'b0;
        smp_valid = 1'b0;
        smp_highg = '0;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        rchk("ctrl", A_CTRL, 32'h0);
        rchk("evt_count", A_EVT_COUNT, 32'h1);
        rchk("thr_hi", A_THR_HI, 32'h7FFF);
        rchk("thr_lo", A_THR_LO, 32'h8000);
        rchk("interval", A_INTERVAL, 32'h1);
        rchk("mask", A_IRQ_MASK, 32'h0);
        rchk("unmapped", 4'hF, 32'h0);
        st(RATC_IDLE);
        // Host start with pre-event window, second start while recording
        wr(A_CTRL, 32'h40);
        wr(A_CMD, 32'h1);
        st(RATC_ARMED);
        chk("pre_len", 32'(rec_pre_len), 32'h7D000);
        base = n_starts;
        wr(A_CMD, 32'h4);
        wait_act(1'b1);
        wr(A_CMD, 32'h4);
        chk("starts", 32'(n_starts - base), 32'h1);
        st(RATC_REC);
        wait_act(1'b0);
        st(RATC_IDLE);
        wr(A_IRQ_MASK, 32'h7);
        @(posedge clk);
        chk("irq", {31'h0, irq}, 32'h1);
        rchk("irq_stat", A_IRQ_STAT, 32'h7);
        chk("irq", {31'h0, irq}, 32'h0);
        // Level trigger: equal values stay quiet, one below and one above fire
        wr(A_THR_HI, 32'h100);
        wr(A_THR_LO, 32'hFF00);
        wr(A_CTRL, 32'h4);
        for (i = 0; i < 2; i++)
        begin
            wr(A_CMD, 32'h1);
            base = n_starts;
            smp({16'h0100, 16'hFF00, 16'h0100});
            chk("starts", 32'(n_starts - base), 32'h0);
            smp(i == 0 ? {16'h0, 16'hFEFF, 16'h0} : {16'h0101, 32'h0});
            chk("starts", 32'(n_starts - base), 32'h1);
            wait_act(1'b1);
            wait_act(1'b0);
        end
        // Event-line start masks level trigger and pre-event data
        wr(A_CTRL, 32'h46);
        wr(A_CMD, 32'h1);
        repeat (3) @(posedge clk);
        chk("low_power", {31'h0, low_power}, 32'h1);
        chk("pre_len", 32'(rec_pre_len), 32'h0);
        base = n_starts;
        smp({16'h7FFF, 16'h8000, 16'h7FFF});
        chk("starts", 32'(n_starts - base), 32'h0);
        wr(A_UTC_NOW, 32'h0000_1234);
        partner_u.close_contact(5);
        wait_act(1'b1);
        chk("starts", 32'(n_starts - base), 32'h1);
        wait_act(1'b0);
        rchk("t0_stamp", A_T0_STAMP, 32'h0000_1234);
        // Motion wake, then host disarm
        wr(A_CTRL, 32'h8);
        wr(A_CMD, 32'h1);
        st(RATC_SLEEP);
        chk("low_power", {31'h0, low_power}, 32'h1);
        motion <= 1'b1;
        repeat (5) @(posedge clk);
        chk("low_power", {31'h0, low_power}, 32'h0);
        st(RATC_ARMED);
        motion <= 1'b0;
        wr(A_CMD, 32'h2);
        st(RATC_IDLE);
        // Interval schedule
        wr(A_CTRL, 32'h61);
        wr(A_CMD, 32'h1);
        chk("pre_len", 32'(rec_pre_len), 32'h0);
        chk("rec_active", {31'h0, rec_active}, 32'h0);
        wait_act(1'b1);
        wait_act(1'b0);
        // Two-event arming
        rchk("done_cnt", A_DONE_CNT, 32'h1);
        wr(A_EVT_COUNT, 32'h2);
        wr(A_CTRL, 32'h10);
        wr(A_CMD, 32'h1);
        for (i = 0; i < 2; i++)
        begin
            wr(A_CMD, 32'h4);
            wait_act(1'b1);
            wait_act(1'b0);
            st(i == 0 ? RATC_ARMED : RATC_IDLE);
        end
        rchk("done_cnt", A_DONE_CNT, 32'h2);
        summarize();
    end
endmodule : record_arm_trigger_control_test
`default_nettype wire
